//--- hw/scl_defines.svh
// offsets, field positions, word addresses and reset values of the config loader
`ifndef SCL_DEFINES_SVH
`define SCL_DEFINES_SVH

// ----------------------------------------------------------------
// image word addresses
// ----------------------------------------------------------------
`define SCL_WORD_PHY_P3   8'h46
`define SCL_WORD_PHY_P4   8'h48
`define SCL_WORD_PHY_P5   8'h4A
`define SCL_WORD_PM_FIRST 8'h50
`define SCL_WORD_PM_LAST  8'h5B
`define SCL_PHY_FIRST_PORT 3'h3

// ----------------------------------------------------------------
// configuration offsets (low byte of the config address)
// ----------------------------------------------------------------
`define SCL_OFS_PMCAP  8'h40
`define SCL_OFS_PMCSR  8'h44
`define SCL_OFS_CMPL   8'h78
`define SCL_OFS_PHY2   8'h7C
`define SCL_OFS_TLCTL  8'h8C
`define SCL_OFS_PHY3   8'h90
`define SCL_OFS_DEEMPH 8'hF0
`define SCL_OFS_CTRL   8'h00
`define SCL_OFS_STAT   8'h04
`define SCL_LOCAL_PORT 3'h7

// ----------------------------------------------------------------
// field positions inside an image word
// ----------------------------------------------------------------
`define SCL_W_PHY2   4:0
`define SCL_W_PHY3   11:5
`define SCL_W_DEEMPH 12
`define SCL_W_CMPL   13
`define SCL_W_DCSEL  15:14
`define SCL_W_NSR    0
`define SCL_W_AUX    3:1
`define SCL_W_PME    7:6
`define SCL_W_PMDATA 15:8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SCL_CTRL_RST 2'h1

`endif

//--- hw/scl_pkg.sv
// types shared by the config loader modules
package scl_pkg;

  // loader sequence, gray coded along idle -> load -> done
  typedef enum logic [1:0] {
    SCL_IDLE = 2'b00,
    SCL_LOAD = 2'b01,
    SCL_DONE = 2'b11
  } scl_state_e;

  // what an image word carries
  typedef enum logic [1:0] {
    SCL_KIND_NONE   = 2'b00,
    SCL_KIND_PHY    = 2'b01,
    SCL_KIND_PMFLAG = 2'b10,
    SCL_KIND_PMDATA = 2'b11
  } scl_kind_e;

endpackage

//--- hw/scl_word_decode.sv
// decodes an image word address into its kind and target port
`timescale 1ns/10ps
`default_nettype none
`include "scl_defines.svh"

module scl_word_decode (
  input  wire logic [7:0]       addr_in,
  output scl_pkg::scl_kind_e    kind_out,
  output logic      [2:0]       port_out
);

  logic [7:0] pm_rel;
  logic [7:0] phy_rel;

  // relative positions inside the two word groups
  assign pm_rel  = addr_in - `SCL_WORD_PM_FIRST;
  assign phy_rel = addr_in - `SCL_WORD_PHY_P3;

  // flag and data words alternate, two per port
  always_comb begin
    kind_out = scl_pkg::SCL_KIND_NONE;
    port_out = 3'h0;
    if (addr_in >= `SCL_WORD_PM_FIRST && addr_in <= `SCL_WORD_PM_LAST) begin
      kind_out = pm_rel[0] ? scl_pkg::SCL_KIND_PMDATA : scl_pkg::SCL_KIND_PMFLAG;
      port_out = pm_rel[3:1];
    end else if (addr_in == `SCL_WORD_PHY_P3 || addr_in == `SCL_WORD_PHY_P4 ||
                 addr_in == `SCL_WORD_PHY_P5) begin
      kind_out = scl_pkg::SCL_KIND_PHY;
      port_out = `SCL_PHY_FIRST_PORT + phy_rel[3:1];
    end
  end

endmodule
`default_nettype wire

//--- hw/scl_loader.sv
// serial image to per-port configuration field loader
//
// Overview of operation
// - word 48h bits 4:0 go to port 4 offset 7Ch bits 12:8
// - physical word bits 11:5 go to that port's offset 90h bits 6:0
// - physical word bit 12 goes to offset F0h bit 6, de-emphasis select
// - physical word bit 13 goes to offset 78h bit 11, compliance to detect
// - physical word bits 15:14 go to offset 8Ch bits 9:8, count select
// - word 4Ah is port 5's physical word with port 4's layout
// - port 3's physical word carries the same fields in bits 12 to 15
// - word 50h bit 0 goes to port 0 offset 44h bit 3, no soft reset
// - power word bits 3:1 go to offset 40h bits 24:22, aux current
// - offset 40h bits 25 and 26 read as 1, D1 and D2 supported
// - power word bits 7:6 go to offset 40h bits 29:28, wake support
// - word 51h bits 15:8 go to port 0 offset 44h bits 31:24
// - port 1 uses words 52h and 53h with the same layout
// - word 46h is port 3's physical word, bits 4:0 to offset 7Ch 12:8
`timescale 1ns/10ps
`default_nettype none
`include "scl_defines.svh"

module scl_loader #(
  parameter int NUM_PORTS = 6
) (
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        mem_word_valid_in,
  input  wire logic [7:0]  mem_word_addr_in,
  input  wire logic [15:0] mem_word_data_in,
  input  wire logic        mem_image_end_in,
  input  wire logic [10:0] cfg_addr_in,
  input  wire logic [31:0] cfg_wdata_in,
  input  wire logic        cfg_wr_in,
  input  wire logic        cfg_rd_in,
  output logic      [31:0] cfg_rdata_out,
  output logic             load_request_out,
  output logic             load_done_out,
  output logic      [NUM_PORTS-1:0] no_soft_reset_out
);

  // ----------------------------------------------------------------
  // loader state and word decode
  // ----------------------------------------------------------------
  scl_pkg::scl_state_e state_q;
  scl_pkg::scl_kind_e  kind;
  logic [2:0]          word_port;
  logic                take;
  logic [1:0]          ctrl_q;
  logic [7:0]          count_q;
  logic                reload;

  scl_word_decode u_decode (
    .addr_in  (mem_word_addr_in),
    .kind_out (kind),
    .port_out (word_port)
  );

  // words count only while loading and enabled; stray words are dropped
  assign take   = mem_word_valid_in && ctrl_q[0] && (state_q == scl_pkg::SCL_LOAD);
  assign reload = cfg_wr_in && (cfg_addr_in[10:8] == `SCL_LOCAL_PORT) &&
                  (cfg_addr_in[7:0] == `SCL_OFS_CTRL) && cfg_wdata_in[1] &&
                  (state_q == scl_pkg::SCL_DONE); // a reload mid-image would restart the count

  // sequence: load once after reset, reload on software request
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_q <= scl_pkg::SCL_IDLE;
    end else begin
      case (state_q)
        scl_pkg::SCL_IDLE: begin
          state_q <= scl_pkg::SCL_LOAD;
        end
        scl_pkg::SCL_LOAD: begin
          if (mem_image_end_in) begin
            state_q <= scl_pkg::SCL_DONE;
          end
        end
        scl_pkg::SCL_DONE: begin
          if (reload) begin
            state_q <= scl_pkg::SCL_LOAD;
          end
        end
        default: begin
          state_q <= scl_pkg::SCL_IDLE;
        end
      endcase
    end
  end

  // control: bit 0 enables word capture; bit 1 is a self-clearing reload
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ctrl_q <= `SCL_CTRL_RST;
    end else if (cfg_wr_in && cfg_addr_in[10:8] == `SCL_LOCAL_PORT &&
                 cfg_addr_in[7:0] == `SCL_OFS_CTRL) begin
      ctrl_q <= {1'b0, cfg_wdata_in[0]};
    end
  end

  // count of words applied since the last load started
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || state_q == scl_pkg::SCL_IDLE || reload) begin
      count_q <= 8'h00;
    end else if (take && kind != scl_pkg::SCL_KIND_NONE) begin
      count_q <= count_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // per-port field storage
  // ----------------------------------------------------------------
  logic [4:0] phy2_q   [NUM_PORTS];
  logic [6:0] phy3_q   [NUM_PORTS];
  logic       deemph_q [NUM_PORTS];
  logic       cmpl_q   [NUM_PORTS];
  logic [1:0] dcsel_q  [NUM_PORTS];
  logic       nsr_q    [NUM_PORTS];
  logic [2:0] aux_q    [NUM_PORTS];
  logic [1:0] pme_q    [NUM_PORTS];
  logic [7:0] pmdata_q [NUM_PORTS];

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      logic hit_phy;
      logic hit_flag;
      logic hit_data;

      // a word lands only in the port it names; ports 0 to 2 have no physical word
      assign hit_phy  = take && kind == scl_pkg::SCL_KIND_PHY    && word_port == 3'(gp);
      assign hit_flag = take && kind == scl_pkg::SCL_KIND_PMFLAG && word_port == 3'(gp);
      assign hit_data = take && kind == scl_pkg::SCL_KIND_PMDATA && word_port == 3'(gp);

      // physical-layer tuning, same layout for ports 3, 4 and 5
      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          phy2_q[gp]   <= 5'h00;
          phy3_q[gp]   <= 7'h00;
          deemph_q[gp] <= 1'b0;
          cmpl_q[gp]   <= 1'b0;
          dcsel_q[gp]  <= 2'h0;
        end else if (hit_phy) begin
          phy2_q[gp]   <= mem_word_data_in[`SCL_W_PHY2];
          phy3_q[gp]   <= mem_word_data_in[`SCL_W_PHY3];
          deemph_q[gp] <= mem_word_data_in[`SCL_W_DEEMPH];
          cmpl_q[gp]   <= mem_word_data_in[`SCL_W_CMPL];
          dcsel_q[gp]  <= mem_word_data_in[`SCL_W_DCSEL];
        end
      end

      // power-management flags word (even address of the pair)
      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          nsr_q[gp] <= 1'b0;
          aux_q[gp] <= 3'h0;
          pme_q[gp] <= 2'h0;
        end else if (hit_flag) begin
          nsr_q[gp] <= mem_word_data_in[`SCL_W_NSR];
          aux_q[gp] <= mem_word_data_in[`SCL_W_AUX];
          pme_q[gp] <= mem_word_data_in[`SCL_W_PME];
        end
      end

      // power-management data byte (odd address of the pair)
      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          pmdata_q[gp] <= 8'h00;
        end else if (hit_data) begin
          pmdata_q[gp] <= mem_word_data_in[`SCL_W_PMDATA];
        end
      end

      // soft-reset policy goes out once the image is complete
      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          no_soft_reset_out[gp] <= 1'b0;
        end else if (state_q == scl_pkg::SCL_DONE) begin
          no_soft_reset_out[gp] <= nsr_q[gp];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // configuration read port
  // ----------------------------------------------------------------
  logic [2:0]  rd_port;
  logic [7:0]  rd_ofs;
  logic [31:0] rd_val;

  assign rd_port = cfg_addr_in[10:8];
  assign rd_ofs  = cfg_addr_in[7:0];

  // read value; port fields read as zero until loading is over, which keeps a
  // half-loaded image from ever being seen
  always_comb begin
    rd_val = 32'h0000_0000;
    if (rd_port == `SCL_LOCAL_PORT) begin
      if (rd_ofs == `SCL_OFS_CTRL) begin
        rd_val = {30'h0000_0000, ctrl_q};
      end else if (rd_ofs == `SCL_OFS_STAT) begin
        rd_val = {16'h0000, count_q, 5'h00, state_q, (state_q == scl_pkg::SCL_DONE)};
      end
    end else if (rd_port < 3'(NUM_PORTS) && state_q == scl_pkg::SCL_DONE) begin
      case (rd_ofs)
        `SCL_OFS_PMCAP: begin
          rd_val = {2'h0, pme_q[rd_port], 1'b0, 1'b1, 1'b1, aux_q[rd_port], 22'h00_0000};
        end
        `SCL_OFS_PMCSR: begin
          rd_val = {pmdata_q[rd_port], 20'h0_0000, nsr_q[rd_port], 3'h0};
        end
        `SCL_OFS_CMPL: begin
          rd_val = {20'h0_0000, cmpl_q[rd_port], 11'h000};
        end
        `SCL_OFS_PHY2: begin
          rd_val = {19'h0_0000, phy2_q[rd_port], 8'h00};
        end
        `SCL_OFS_TLCTL: begin
          rd_val = {22'h00_0000, dcsel_q[rd_port], 8'h00};
        end
        `SCL_OFS_PHY3: begin
          rd_val = {25'h000_0000, phy3_q[rd_port]};
        end
        `SCL_OFS_DEEMPH: begin
          rd_val = {25'h000_0000, deemph_q[rd_port], 6'h00};
        end
        default: begin
          rd_val = 32'h0000_0000;
        end
      endcase
    end
  end

  // read data stand for exactly the cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cfg_rdata_out <= 32'h0000_0000;
    end else begin
      cfg_rdata_out <= cfg_rd_in ? rd_val : 32'h0000_0000;
    end
  end

  // handshake with the serial reader
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      load_request_out <= 1'b0;
      load_done_out    <= 1'b0;
    end else begin
      load_request_out <= (state_q == scl_pkg::SCL_LOAD) && !mem_image_end_in;
      load_done_out    <= (state_q == scl_pkg::SCL_DONE) && !reload;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_port4_phy2_copy: assert property (
    take && mem_word_addr_in == `SCL_WORD_PHY_P4 |=>
      phy2_q[4] == $past(mem_word_data_in[`SCL_W_PHY2]))
    else $error("port 4 phy parameter two not loaded");

  a_phy3_copy: assert property (
    take && mem_word_addr_in == `SCL_WORD_PHY_P4 |=>
      phy3_q[4] == $past(mem_word_data_in[`SCL_W_PHY3]))
    else $error("port 4 phy parameter three not loaded");

  a_phy3_read_back: assert property (
    cfg_rd_in && cfg_addr_in == {3'h4, `SCL_OFS_PHY3} && state_q == scl_pkg::SCL_DONE |=>
      cfg_rdata_out == {25'h000_0000, $past(phy3_q[4])})
    else $error("phy parameter three read back wrong");

  a_port4_fields_copy: assert property (
    take && mem_word_addr_in == `SCL_WORD_PHY_P4 |=>
      dcsel_q[4] == $past(mem_word_data_in[`SCL_W_DCSEL]) &&
      cmpl_q[4] == $past(mem_word_data_in[`SCL_W_CMPL]))
    else $error("port 4 count select or compliance not loaded");

  a_deemph_cmpl_copy: assert property (
    take && kind == scl_pkg::SCL_KIND_PHY && word_port == 3'h5 |=>
      deemph_q[5] == $past(mem_word_data_in[`SCL_W_DEEMPH]) &&
      cmpl_q[5] == $past(mem_word_data_in[`SCL_W_CMPL]))
    else $error("port 5 de-emphasis or compliance not loaded");

  a_port5_decode: assert property (
    mem_word_addr_in == `SCL_WORD_PHY_P5 |->
      kind == scl_pkg::SCL_KIND_PHY && word_port == 3'h5)
    else $error("word for port 5 decoded wrong");

  a_port3_decode: assert property (
    mem_word_addr_in == `SCL_WORD_PHY_P3 |->
      kind == scl_pkg::SCL_KIND_PHY && word_port == 3'h3)
    else $error("word for port 3 decoded wrong");

  a_port3_dcsel_copy: assert property (
    take && mem_word_addr_in == `SCL_WORD_PHY_P3 |=>
      dcsel_q[3] == $past(mem_word_data_in[`SCL_W_DCSEL]) &&
      phy2_q[3] == $past(mem_word_data_in[`SCL_W_PHY2]))
    else $error("port 3 physical word not loaded");

  a_port0_flags_copy: assert property (
    take && mem_word_addr_in == `SCL_WORD_PM_FIRST |=>
      nsr_q[0] == $past(mem_word_data_in[`SCL_W_NSR]) &&
      aux_q[0] == $past(mem_word_data_in[`SCL_W_AUX]) &&
      pme_q[0] == $past(mem_word_data_in[`SCL_W_PME]))
    else $error("port 0 power flags not loaded");

  a_pmcap_fixed_ones: assert property (
    cfg_rd_in && rd_ofs == `SCL_OFS_PMCAP && rd_port < 3'(NUM_PORTS) &&
      state_q == scl_pkg::SCL_DONE |=> cfg_rdata_out[26:25] == 2'h3)
    else $error("d1 and d2 support bits not read as one");

  a_port1_data_copy: assert property (
    take && mem_word_addr_in == `SCL_WORD_PM_FIRST + 8'h03 |=>
      pmdata_q[1] == $past(mem_word_data_in[`SCL_W_PMDATA]))
    else $error("port 1 power data byte not loaded");

  a_port0_data_copy: assert property (
    take && mem_word_addr_in == `SCL_WORD_PM_FIRST + 8'h01 |=>
      pmdata_q[0] == $past(mem_word_data_in[`SCL_W_PMDATA]))
    else $error("port 0 power data byte not loaded");

  // capture off keeps the previous image intact; refused words leave the count unchanged
  a_word_refused: assert property (
    mem_word_valid_in && !ctrl_q[0] && mem_word_addr_in == `SCL_WORD_PHY_P4 |=>
      $stable(phy2_q[4]) && $stable(count_q))
    else $error("word taken while capture disabled");

  a_req_done_apart: assert property (
    load_request_out |-> !load_done_out)
    else $error("request and done high together");

  a_done_follows: assert property (
    state_q == scl_pkg::SCL_DONE && !reload |=> load_done_out)
    else $error("done flag missing after loading");

  a_hidden_while_load: assert property (
    cfg_rd_in && rd_port != `SCL_LOCAL_PORT && state_q != scl_pkg::SCL_DONE |=>
      cfg_rdata_out == 32'h0000_0000)
    else $error("port field visible before loading finished");

  a_rdata_one_cycle: assert property (
    !cfg_rd_in |=> cfg_rdata_out == 32'h0000_0000)
    else $error("read data outside the answer cycle");

  c_full_load: cover property (
    state_q == scl_pkg::SCL_LOAD ##[1:200] state_q == scl_pkg::SCL_DONE);
  c_port5_phy: cover property (take && mem_word_addr_in == `SCL_WORD_PHY_P5);
  c_reload: cover property (state_q == scl_pkg::SCL_DONE && reload);

endmodule
`default_nettype wire

//--- tb/scl_image_model.sv
// behavioural serial image memory that streams words to the loader
`timescale 1ns/10ps
`default_nettype none

module scl_image_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        load_request_in,
  input  wire logic [3:0]  gap_in,
  output logic             valid_out,
  output logic      [7:0]  addr_out,
  output logic      [15:0] data_out,
  output logic             image_end_out
);
  // ----------------------------------------------------------------
  // image contents and streaming
  // ----------------------------------------------------------------
  logic       run_q;
  logic       sent_q;
  logic [7:0] next_q;
  logic [3:0] wait_q;
  logic [7:0] pass_q;

  // contents change with every pass so a stale field is caught
  function automatic logic [15:0] word_of(input logic [7:0] a, input logic [7:0] p);
    return {a ^ 8'h5A ^ p, (a * 8'h07) ^ p};
  endfunction

  // walks 46h..5Bh, unmapped words too; idle lines toggle so nothing stale is seen
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      {run_q, sent_q, valid_out, image_end_out} <= 4'h0;
      {next_q, wait_q, pass_q, addr_out, data_out} <= 44'h000_0000_0000;
    end else begin
      valid_out     <= 1'b0;
      image_end_out <= 1'b0;
      addr_out      <= ~addr_out;
      data_out      <= ~data_out;
      if (!load_request_in) sent_q <= 1'b0;
      if (run_q) begin
        if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
        else if (next_q > 8'h5B) begin
          image_end_out <= 1'b1;
          {run_q, sent_q} <= 2'b01;
          pass_q        <= pass_q + 8'h01;
        end else begin
          valid_out <= 1'b1;
          addr_out  <= next_q;
          data_out  <= word_of(next_q, pass_q);
          next_q    <= next_q + 8'h01;
          wait_q    <= gap_in;
        end
      end else if (load_request_in && !sent_q) begin
        run_q  <= 1'b1;
        next_q <= 8'h46;
        wait_q <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/scl_loader_tb_top.sv
// self-checking bench of the config loader against the image model
`timescale 1ns/10ps
`default_nettype none

module scl_loader_tb_top;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic        clk;
  logic        rst;
  logic        m_valid;
  logic [7:0]  m_addr;
  logic [15:0] m_data;
  logic        m_end;
  logic [3:0]  gap;
  logic [10:0] c_addr;
  logic [31:0] c_wdata;
  logic        c_wr;
  logic        c_rd;
  logic [31:0] c_rdata;
  logic        req;
  logic        done;
  logic [5:0]  nsr;
  logic [31:0] got;
  int          n_fail;
  int          n_checks;
  logic [7:0]  ofs [8] = '{8'h40, 8'h44, 8'h78, 8'h7C, 8'h8C, 8'h90, 8'hF0, 8'h10};

  `define TB_CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

  scl_loader DUT (.ref_clk_in(clk), .sys_rst_in(rst), .mem_word_valid_in(m_valid), .mem_word_addr_in(m_addr),
    .mem_word_data_in(m_data), .mem_image_end_in(m_end), .cfg_addr_in(c_addr), .cfg_wdata_in(c_wdata),
    .cfg_wr_in(c_wr), .cfg_rd_in(c_rd), .cfg_rdata_out(c_rdata), .load_request_out(req),
    .load_done_out(done), .no_soft_reset_out(nsr));

  scl_image_model P (.clk_in(clk), .rst_in(rst), .load_request_in(req), .gap_in(gap), .valid_out(m_valid),
    .addr_out(m_addr), .data_out(m_data), .image_end_out(m_end));

  // clock generation, 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // access tasks and expectations
  // ----------------------------------------------------------------
  // same contents as the model holds, kept separate on purpose
  function automatic logic [15:0] img_word(input logic [7:0] a, input logic [7:0] p);
    return {a ^ 8'h5A ^ p, (a * 8'h07) ^ p};
  endfunction

  // field a port offset must show once loading has ended
  function automatic logic [31:0] exp_field(input int p, input logic [7:0] o, input logic [7:0] ps);
    logic [15:0] w;
    logic [15:0] f;
    logic [15:0] d;
    w = img_word(8'h46 + 8'(2 * (p - 3)), ps);
    f = img_word(8'h50 + 8'(2 * p), ps);
    d = img_word(8'h51 + 8'(2 * p), ps);
    exp_field = 32'h0000_0000;
    if (o == 8'h40) exp_field = {2'b00, f[7:6], 1'b0, 2'b11, f[3:1], 22'h0};
    else if (o == 8'h44) exp_field = {d[15:8], 20'h0, f[0], 3'h0};
    else if (p >= 3) begin
      case (o)
        8'h7C: exp_field = {19'h0, w[4:0], 8'h00};
        8'h90: exp_field = {25'h0, w[11:5]};
        8'hF0: exp_field = {25'h0, w[12], 6'h00};
        8'h78: exp_field = {20'h0, w[13], 11'h0};
        8'h8C: exp_field = {22'h0, w[15:14], 8'h00};
        default: exp_field = 32'h0000_0000;
      endcase
    end
  endfunction

  task automatic cfg_write(input logic [10:0] a, input logic [31:0] d);
    @(posedge clk);
    c_wr    <= 1'b1;
    c_addr  <= a;
    c_wdata <= d;
    @(posedge clk);
    c_wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic cfg_read(input logic [10:0] a, input logic [31:0] e);
    @(posedge clk);
    c_rd   <= 1'b1;
    c_addr <= a;
    @(posedge clk);
    c_rd <= 1'b0;
    #1;
    got = c_rdata;
    `TB_CHK(got, e)
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // bounded wait for the end of loading
  task automatic wait_done();
    for (int i = 0; i < 1000; i++) begin
      if (done === 1'b1) return;
      @(posedge clk);
      #1;
    end
    n_fail++;
    $display("wrong value at %0t: got %h expected %h", $time, done, 1'b1);
    conclude();
  endtask

  // every offset of every port, unmapped 10h included
  task automatic check_all(input logic [7:0] ps);
    logic [15:0] f;
    `TB_CHK(req, 1'b0)
    for (int p = 0; p < 6; p++) begin
      f = img_word(8'h50 + 8'(2 * p), ps);
      `TB_CHK(nsr[p], f[0])
      for (int k = 0; k < 8; k++) begin
        cfg_read({3'(p), ofs[k]}, exp_field(p, ofs[k], ps));
      end
    end
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, c_wr, c_rd, gap, c_addr, c_wdata} = 50'h2_0000_0000_0000;
    n_fail = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cfg_read({3'h0, 8'h40}, 32'h0000_0000);
    cfg_read({3'h7, 8'h00}, 32'h0000_0001);
    wait_done();
    $display("test hidden before load done");
    check_all(8'h00);
    // fifteen mapped words taken, state done, done flag
    cfg_read({3'h7, 8'h04}, 32'h0000_0F07);
    cfg_write({3'h4, 8'h7C}, 32'hFFFF_FFFF);
    cfg_read({3'h4, 8'h7C}, exp_field(4, 8'h7C, 8'h00));
    $display("test first image done");
    // reload with a slow image: fields hide until the new image lands
    gap <= 4'h3;
    cfg_write({3'h7, 8'h00}, 32'h0000_0003);
    `TB_CHK(done, 1'b0)
    cfg_read({3'h4, 8'h7C}, 32'h0000_0000);
    `TB_CHK(req, 1'b1)
    wait_done();
    check_all(8'h01);
    $display("test reload done");
    // capture off: the image streams past and every field keeps the last one
    cfg_write({3'h7, 8'h00}, 32'h0000_0002);
    `TB_CHK(done, 1'b0)
    wait_done();
    cfg_read({3'h7, 8'h04}, 32'h0000_0007);
    cfg_read({3'h7, 8'h00}, 32'h0000_0000);
    check_all(8'h01);
    $display("test capture off done");
    conclude();
  end
endmodule
`default_nettype wire
